// ==== rtl/cfe_pkg.sv ====
/*
  Shared definitions for the CAN filter and transmit-event block: message RAM
  word layouts, event and filter codes, configuration and result carriers.
  Assumes a 32-bit message RAM addressed in words and a single host clock.
*/
package cfe_pkg;

  // identifier widths
  localparam int ID_W = 29;
  localparam int STD_ID_W = 11;
  localparam int STD_ID_LSB = 18; // a standard id sits in id[28:18]

  // event type codes of the transmit-event record
  localparam logic [1:0] ET_TX = 2'h1;
  localparam logic [1:0] ET_CANCEL = 2'h2;

  // filter type codes
  localparam logic [1:0] FT_RANGE = 2'h0;
  localparam logic [1:0] FT_DUAL = 2'h1;
  localparam logic [1:0] FT_CLASSIC = 2'h2;
  localparam logic [1:0] FT_OFF = 2'h3; // disabled (std), unmasked range (ext)

  // filter element action codes
  localparam logic [2:0] ACT_DISABLE = 3'h0;
  localparam logic [2:0] ACT_FIFO0 = 3'h1;
  localparam logic [2:0] ACT_FIFO1 = 3'h2;
  localparam logic [2:0] ACT_REJECT = 3'h3;
  localparam logic [2:0] ACT_PRIO = 3'h4;
  localparam logic [2:0] ACT_PRIO_FIFO0 = 3'h5;
  localparam logic [2:0] ACT_PRIO_FIFO1 = 3'h6;
  localparam logic [2:0] ACT_EXACT = 3'h7;

  // exact-match routing codes
  localparam logic [1:0] ROUTE_RXBUF = 2'h0;

  // timestamp and data length constants
  localparam logic [15:0] TS_STEP = 16'h0001;
  localparam logic [3:0] PRE_STEP = 4'h1;
  localparam logic [3:0] DLC_CLASSIC_MAX = 4'h8;
  localparam logic [6:0] BYTES_CLASSIC_MAX = 7'h08;

  // list walk constants
  localparam logic [15:0] ADDR_STEP = 16'h0001;
  localparam logic [7:0] IDX_STEP = 8'h01;

  // filter walk state, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CAP0 = 4'b0010,
    ST_CAP1 = 4'b0100,
    ST_EVAL = 4'b1000
  } cfe_fsm_t;

  // frame description handed over when a transmission completes
  typedef struct packed {
    logic esi;
    logic xtd;
    logic rtr;
    logic [28:0] id;
    logic [7:0] message_marker;
    logic store_event;
    logic cancel_req;
    logic fdf;
    logic brs;
    logic [3:0] dlc;
  } cfe_tx_frame_t;

  // first and second word of a transmit-event record
  typedef struct packed {
    logic esi;
    logic xtd;
    logic rtr;
    logic [28:0] id;
  } cfe_evt_w0_t;

  typedef struct packed {
    logic [7:0] message_marker;
    logic [1:0] event_type;
    logic fdf;
    logic brs;
    logic [3:0] dlc;
    logic [15:0] tx_timestamp;
  } cfe_evt_w1_t;

  // standard filter word and the two extended filter words
  typedef struct packed {
    logic [1:0] std_filter_type;
    logic [2:0] std_filter_action;
    logic [10:0] std_first_id;
    logic [4:0] rsvd;
    logic [10:0] std_second_id;
  } cfe_std_word_t;

  typedef struct packed {
    logic [2:0] ext_filter_action;
    logic [28:0] ext_first_id;
  } cfe_ext_w0_t;

  typedef struct packed {
    logic [1:0] ext_filter_type;
    logic rsvd;
    logic [28:0] ext_second_id;
  } cfe_ext_w1_t;

  // low 11 bits of the second id under the exact-match action
  typedef struct packed {
    logic [1:0] route;
    logic [2:0] fe_enable;
    logic [5:0] offset;
  } cfe_exact_cfg_t;

  // filter configuration
  typedef struct packed {
    logic [15:0] std_filter_list_base;
    logic [7:0] std_count;
    logic [15:0] ext_filter_list_base;
    logic [6:0] ext_count;
    logic [15:0] rx_buffer_base;
    logic [28:0] global_ext_and_mask;
  } cfe_filt_cfg_t;

  // filter decision
  typedef struct packed {
    logic matched;
    logic ext;
    logic [6:0] index;
    logic [2:0] action;
    logic priority_set;
    logic [1:0] route;
    logic [15:0] buf_addr;
  } cfe_rx_result_t;

  // high priority match status
  typedef struct packed {
    logic ext;
    logic [6:0] index;
    logic [1:0] dest; // 00 none, 01 fifo 0, 10 fifo 1
  } cfe_hpm_status_t;

  // payload size from data length code and frame format
  function automatic logic [6:0] cfe_dlc_bytes(input logic [3:0] dlc, input logic fd);
    logic [6:0] b;
    b = {3'h0, dlc};
    if (dlc > DLC_CLASSIC_MAX) begin
      if (!fd) begin
        b = BYTES_CLASSIC_MAX;
      end else begin
        case (dlc)
          4'h9: b = 7'h0C;
          4'hA: b = 7'h10;
          4'hB: b = 7'h14;
          4'hC: b = 7'h18;
          4'hD: b = 7'h20;
          4'hE: b = 7'h30;
          default: b = 7'h40;
        endcase
      end
    end
    return b;
  endfunction

endpackage

// ==== rtl/cfe_id_match.sv ====
/*
  Identifier comparator for one filter element: range, dual, classic mask
  and exact match. Purely combinational; the caller applies any global mask
  and decides whether the element is enabled.
*/
`timescale 1ns/100ps
module cfe_id_match (
  input wire logic [28:0] rx_id,
  input wire logic [28:0] id1,
  input wire logic [28:0] id2,
  input wire logic [1:0] ftype,
  input wire logic exact,
  output logic hit
);

  // compare the received id against the element
  always_comb begin
    hit = 1'b0;
    if (exact) begin
      hit = (rx_id == id1);
    end else begin
      case (ftype)
        cfe_pkg::FT_DUAL: hit = (rx_id == id1) || (rx_id == id2);
        cfe_pkg::FT_CLASSIC: hit = (((rx_id ^ id1) & id2) == '0);
        default: hit = (rx_id >= id1) && (rx_id <= id2); // range, both ends inclusive
      endcase
    end
  end

endmodule

// ==== rtl/cfe_filter_core.sv ====
/*
  Transmit-event record builder and acceptance filter walker of a CAN
  controller. Event records are written to the message RAM through a write
  strobe; filter elements are fetched from the message RAM over a read port
  with no read latency. All inputs come from logic on CLK.
*/
`timescale 1ns/100ps
module cfe_filter_core (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [3:0] TIMESTAMP_PRESCALER,
  input wire logic NO_AUTO_RETRANSMIT_MODE,
  input wire logic TX_SOF,
  input wire logic TX_DONE,
  input wire cfe_pkg::cfe_tx_frame_t TX_FRAME,
  output logic EVT_WR,
  output logic [31:0] EVT_WORD0,
  output logic [31:0] EVT_WORD1,
  output logic [6:0] EVT_BYTES,
  input wire cfe_pkg::cfe_filt_cfg_t FILT_CFG,
  input wire logic RX_START,
  input wire logic [28:0] RX_ID,
  input wire logic RX_XTD,
  output logic RX_BUSY,
  output logic RAM_RD,
  output logic [15:0] RAM_ADDR,
  input wire logic [31:0] RAM_RDATA,
  output logic RES_VALID,
  output cfe_pkg::cfe_rx_result_t RES,
  input wire logic HPM_CLEAR,
  input wire logic HPM_IE,
  output logic HIGH_PRIORITY_MATCH_FLAG,
  output logic HPM_IRQ,
  output cfe_pkg::cfe_hpm_status_t HIGH_PRIORITY_STATUS,
  output logic [2:0] FILTER_EVENT_PULSES
);

  // complete state of the block
  typedef struct packed {
    cfe_pkg::cfe_fsm_t fsm;
    logic [3:0] pre_cnt;
    logic [15:0] ts;
    logic [15:0] sof_ts;
    logic evt_wr;
    cfe_pkg::cfe_evt_w0_t evt_w0;
    cfe_pkg::cfe_evt_w1_t evt_w1;
    logic [6:0] evt_bytes;
    logic [28:0] rx_id;
    logic rx_xtd;
    logic [7:0] idx;
    logic [31:0] w0;
    logic [31:0] w1;
    logic ram_rd;
    logic [15:0] ram_addr;
    logic busy;
    logic res_valid;
    cfe_pkg::cfe_rx_result_t res;
    logic hpm_flag;
    logic hpm_irq;
    cfe_pkg::cfe_hpm_status_t hpm_stat;
    logic [2:0] fe;
  } cfe_state_t;

  cfe_state_t state_reg;
  cfe_state_t state_next;

  // decoded view of the fetched element
  cfe_pkg::cfe_std_word_t std_w;
  cfe_pkg::cfe_ext_w0_t ext_w0;
  cfe_pkg::cfe_ext_w1_t ext_w1;
  cfe_pkg::cfe_exact_cfg_t exact_cfg;
  logic [2:0] act;
  logic [1:0] ftype;
  logic [28:0] id1;
  logic [28:0] id2;
  logic [28:0] cmp_id;
  logic exact;
  logic enabled;
  logic hit;
  logic last_elem;
  logic [7:0] list_count;

  // message RAM word address of element idx in the standard or extended list
  function automatic logic [15:0] elem_addr(input logic ext, input logic [7:0] idx,
                                            input cfe_pkg::cfe_filt_cfg_t cfg);
    logic [15:0] a;
    if (ext) begin
      a = cfg.ext_filter_list_base + {7'h00, idx, 1'b0};
    end else begin
      a = cfg.std_filter_list_base + {8'h00, idx};
    end
    return a;
  endfunction

  // split the fetched words into element fields
  always_comb begin
    std_w = cfe_pkg::cfe_std_word_t'(state_reg.w0);
    ext_w0 = cfe_pkg::cfe_ext_w0_t'(state_reg.w0);
    ext_w1 = cfe_pkg::cfe_ext_w1_t'(state_reg.w1);
    if (state_reg.rx_xtd) begin
      act = ext_w0.ext_filter_action;
      ftype = ext_w1.ext_filter_type;
      id1 = ext_w0.ext_first_id;
      id2 = ext_w1.ext_second_id;
      list_count = {1'b0, FILT_CFG.ext_count};
    end else begin
      act = std_w.std_filter_action;
      ftype = std_w.std_filter_type;
      id1 = {18'h00000, std_w.std_first_id};
      id2 = {18'h00000, std_w.std_second_id};
      list_count = FILT_CFG.std_count;
    end
    exact = (act == cfe_pkg::ACT_EXACT);
    exact_cfg = cfe_pkg::cfe_exact_cfg_t'(id2[10:0]);
    // global mask on extended ids, left off for the unmasked range type
    if (!state_reg.rx_xtd) begin
      cmp_id = {18'h00000, state_reg.rx_id[cfe_pkg::ID_W-1:cfe_pkg::STD_ID_LSB]};
    end else if (!exact && ftype == cfe_pkg::FT_OFF) begin
      cmp_id = state_reg.rx_id;
    end else begin
      cmp_id = state_reg.rx_id & FILT_CFG.global_ext_and_mask;
    end
    // action 000 and standard type 11 outside exact match both skip the element
    enabled = (act != cfe_pkg::ACT_DISABLE) &&
              !(!state_reg.rx_xtd && !exact && ftype == cfe_pkg::FT_OFF);
    last_elem = ((state_reg.idx + cfe_pkg::IDX_STEP) >= list_count);
  end

  // id comparison for the current element
  cfe_id_match u_match (
    .rx_id(cmp_id),
    .id1(id1),
    .id2(id2),
    .ftype(ftype),
    .exact(exact),
    .hit(hit)
  );

  // next-state logic: timestamp, event records, filter walk, priority flag
  always_comb begin
    logic hpm_set;
    cfe_pkg::cfe_evt_w0_t w0;
    cfe_pkg::cfe_evt_w1_t w1;
    hpm_set = 1'b0;
    w0 = '0;
    w1 = '0;
    state_next = state_reg;
    state_next.evt_wr = 1'b0;
    state_next.res_valid = 1'b0;
    state_next.ram_rd = 1'b0;
    state_next.fe = 3'h0;

    // timestamp counter advancing once per prescaler period
    if (state_reg.pre_cnt >= TIMESTAMP_PRESCALER) begin
      state_next.pre_cnt = 4'h0;
      state_next.ts = state_reg.ts + cfe_pkg::TS_STEP;
    end else begin
      state_next.pre_cnt = state_reg.pre_cnt + cfe_pkg::PRE_STEP;
    end
    if (TX_SOF) begin
      state_next.sof_ts = state_reg.ts;
    end

    // one record per completed frame that asks for an event, in completion order
    if (TX_DONE && TX_FRAME.store_event) begin
      w0.esi = TX_FRAME.esi;
      w0.xtd = TX_FRAME.xtd;
      w0.rtr = TX_FRAME.rtr;
      if (TX_FRAME.xtd) begin
        w0.id = TX_FRAME.id;
      end else begin
        w0.id = {TX_FRAME.id[cfe_pkg::ID_W-1:cfe_pkg::STD_ID_LSB], 18'h00000};
      end
      w1.message_marker = TX_FRAME.message_marker;
      if (TX_FRAME.cancel_req || NO_AUTO_RETRANSMIT_MODE) begin
        w1.event_type = cfe_pkg::ET_CANCEL;
      end else begin
        w1.event_type = cfe_pkg::ET_TX;
      end
      w1.fdf = TX_FRAME.fdf;
      w1.brs = TX_FRAME.brs;
      w1.dlc = TX_FRAME.dlc;
      w1.tx_timestamp = state_reg.sof_ts;
      state_next.evt_w0 = w0;
      state_next.evt_w1 = w1;
      state_next.evt_bytes = cfe_pkg::cfe_dlc_bytes(TX_FRAME.dlc, TX_FRAME.fdf);
      state_next.evt_wr = 1'b1;
    end

    // acceptance filter walk
    case (state_reg.fsm)
      cfe_pkg::ST_IDLE: begin
        if (RX_START) begin
          state_next.rx_id = RX_ID;
          state_next.rx_xtd = RX_XTD;
          state_next.idx = 8'h00;
          if ((RX_XTD && FILT_CFG.ext_count == 7'h00) ||
              (!RX_XTD && FILT_CFG.std_count == 8'h00)) begin
            // empty list: answer at once with no match
            state_next.res_valid = 1'b1;
            state_next.res = '0;
            state_next.res.ext = RX_XTD;
          end else begin
            state_next.busy = 1'b1;
            state_next.ram_rd = 1'b1;
            state_next.ram_addr = elem_addr(RX_XTD, 8'h00, FILT_CFG);
            state_next.fsm = cfe_pkg::ST_CAP0;
          end
        end
      end
      cfe_pkg::ST_CAP0: begin
        state_next.w0 = RAM_RDATA;
        if (state_reg.rx_xtd) begin
          // second word of the extended element
          state_next.ram_rd = 1'b1;
          state_next.ram_addr = state_reg.ram_addr + cfe_pkg::ADDR_STEP;
          state_next.fsm = cfe_pkg::ST_CAP1;
        end else begin
          state_next.fsm = cfe_pkg::ST_EVAL;
        end
      end
      cfe_pkg::ST_CAP1: begin
        state_next.w1 = RAM_RDATA;
        state_next.fsm = cfe_pkg::ST_EVAL;
      end
      cfe_pkg::ST_EVAL: begin
        if (enabled && hit) begin
          // first enabled matching element ends the walk
          state_next.res.matched = 1'b1;
          state_next.res.ext = state_reg.rx_xtd;
          state_next.res.index = state_reg.idx[6:0];
          state_next.res.action = act;
          state_next.res.priority_set = (act == cfe_pkg::ACT_PRIO) ||
                                        (act == cfe_pkg::ACT_PRIO_FIFO0) ||
                                        (act == cfe_pkg::ACT_PRIO_FIFO1);
          state_next.res.route = exact ? exact_cfg.route : cfe_pkg::ROUTE_RXBUF;
          state_next.res.buf_addr = 16'h0000;
          if (exact && exact_cfg.route == cfe_pkg::ROUTE_RXBUF) begin
            state_next.res.buf_addr = FILT_CFG.rx_buffer_base +
                                      {10'h000, exact_cfg.offset};
          end
          if (exact) begin
            state_next.fe = exact_cfg.fe_enable;
          end
          if (state_next.res.priority_set) begin
            hpm_set = 1'b1;
            state_next.hpm_stat.ext = state_reg.rx_xtd;
            state_next.hpm_stat.index = state_reg.idx[6:0];
            state_next.hpm_stat.dest = act[1:0];
          end
          state_next.res_valid = 1'b1;
          state_next.busy = 1'b0;
          state_next.fsm = cfe_pkg::ST_IDLE;
        end else if (last_elem) begin
          // end of list without a match
          state_next.res = '0;
          state_next.res.ext = state_reg.rx_xtd;
          state_next.res_valid = 1'b1;
          state_next.busy = 1'b0;
          state_next.fsm = cfe_pkg::ST_IDLE;
        end else begin
          // next element in list order
          state_next.idx = state_reg.idx + cfe_pkg::IDX_STEP;
          state_next.ram_rd = 1'b1;
          state_next.ram_addr = elem_addr(state_reg.rx_xtd,
                                          state_reg.idx + cfe_pkg::IDX_STEP, FILT_CFG);
          state_next.fsm = cfe_pkg::ST_CAP0;
        end
      end
      default: begin
        state_next.fsm = cfe_pkg::ST_IDLE;
        state_next.busy = 1'b0;
      end
    endcase

    // sticky priority flag; a new match beats a clear in the same cycle
    state_next.hpm_flag = hpm_set | (state_reg.hpm_flag & ~HPM_CLEAR);
    state_next.hpm_irq = state_next.hpm_flag & HPM_IE;
  end

  // state register
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_reg <= '0;
      state_reg.fsm <= cfe_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register
  assign EVT_WR = state_reg.evt_wr;
  assign EVT_WORD0 = state_reg.evt_w0;
  assign EVT_WORD1 = state_reg.evt_w1;
  assign EVT_BYTES = state_reg.evt_bytes;
  assign RX_BUSY = state_reg.busy;
  assign RAM_RD = state_reg.ram_rd;
  assign RAM_ADDR = state_reg.ram_addr;
  assign RES_VALID = state_reg.res_valid;
  assign RES = state_reg.res;
  assign HIGH_PRIORITY_MATCH_FLAG = state_reg.hpm_flag;
  assign HPM_IRQ = state_reg.hpm_irq;
  assign HIGH_PRIORITY_STATUS = state_reg.hpm_stat;
  assign FILTER_EVENT_PULSES = state_reg.fe; // one clock per exact match

endmodule

// ==== testbench/cfe_core_properties.sv ====
/*
  Port checker for the filter and transmit-event core.
  Assumes one clock domain and a bind onto every core instance.
*/
`timescale 1ns/100ps
module cfe_core_props (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic NO_AUTO_RETRANSMIT_MODE,
  input wire logic TX_DONE,
  input wire cfe_pkg::cfe_tx_frame_t TX_FRAME,
  input wire logic EVT_WR,
  input wire logic [31:0] EVT_WORD0,
  input wire logic [31:0] EVT_WORD1,
  input wire logic RX_BUSY,
  input wire logic RAM_RD,
  input wire logic [15:0] RAM_ADDR,
  input wire logic RES_VALID,
  input wire cfe_pkg::cfe_rx_result_t RES,
  input wire logic HPM_IE,
  input wire logic HIGH_PRIORITY_MATCH_FLAG,
  input wire logic HPM_IRQ,
  input wire logic [2:0] FILTER_EVENT_PULSES
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  logic take;
  logic [31:0] w0_in;
  // a transmission that asks for an event record
  assign take = TX_DONE && TX_FRAME.store_event;
  assign w0_in = {TX_FRAME.esi, TX_FRAME.xtd, TX_FRAME.rtr,
    TX_FRAME.xtd ? TX_FRAME.id : {TX_FRAME.id[28:18], 18'h0}};
  a_evt_wr_timing: assert property (TX_DONE |=> EVT_WR == $past(TX_FRAME.store_event))
    else $error("event write not one cycle after done");
  a_evt_id_word: assert property (take |=> EVT_WORD0 == $past(w0_in))
    else $error("event word0 wrong");
  a_evt_marker_fmt: assert property (take |=> EVT_WORD1[31:24] == $past(TX_FRAME.message_marker)
    && EVT_WORD1[21:16] == $past({TX_FRAME.fdf, TX_FRAME.brs, TX_FRAME.dlc}))
    else $error("event word1 fields wrong");
  a_evt_type_code: assert property (take |=> EVT_WORD1[23:22] ==
    ($past(TX_FRAME.cancel_req || NO_AUTO_RETRANSMIT_MODE) ? 2'h2 : 2'h1))
    else $error("event type wrong");
  a_ext_word_pair: assert property (RAM_RD ##1 RAM_RD |-> RAM_ADDR == $past(RAM_ADDR) + 16'h0001)
    else $error("second element word not at next address");
  a_read_in_walk: assert property (RAM_RD |-> RX_BUSY)
    else $error("read outside a walk");
  a_fe_exact_only: assert property (FILTER_EVENT_PULSES != 3'h0 |->
    RES_VALID && RES.matched && RES.action == cfe_pkg::ACT_EXACT)
    else $error("filter event without exact match");
  a_fe_one_cycle: assert property (FILTER_EVENT_PULSES != 3'h0 |=> FILTER_EVENT_PULSES == 3'h0)
    else $error("filter event longer than one cycle");
  a_prio_code_set: assert property (RES_VALID && RES.matched |->
    RES.priority_set == (RES.action inside {3'h4, 3'h5, 3'h6}))
    else $error("priority decode wrong");
  a_hpm_flag_set: assert property (RES_VALID && RES.priority_set |-> HIGH_PRIORITY_MATCH_FLAG)
    else $error("priority flag not set");
  a_hpm_irq_gate: assert property (HPM_IRQ == (HIGH_PRIORITY_MATCH_FLAG && $past(HPM_IE)))
    else $error("priority interrupt wrong");
endmodule
bind cfe_filter_core cfe_core_props u_props (.CLK(CLK), .RST_N(RST_N),
  .NO_AUTO_RETRANSMIT_MODE(NO_AUTO_RETRANSMIT_MODE), .TX_DONE(TX_DONE), .TX_FRAME(TX_FRAME),
  .EVT_WR(EVT_WR), .EVT_WORD0(EVT_WORD0), .EVT_WORD1(EVT_WORD1), .RX_BUSY(RX_BUSY),
  .RAM_RD(RAM_RD), .RAM_ADDR(RAM_ADDR), .RES_VALID(RES_VALID), .RES(RES), .HPM_IE(HPM_IE),
  .HIGH_PRIORITY_MATCH_FLAG(HIGH_PRIORITY_MATCH_FLAG), .HPM_IRQ(HPM_IRQ),
  .FILTER_EVENT_PULSES(FILTER_EVENT_PULSES));

// ==== testbench/cfe_ram_model.sv ====
/*
  Message RAM model behind the core's read port.
  Assumes the bench loads filter words through the write port while idle.
*/
`timescale 1ns/100ps
module cfe_ram_model (
  input wire logic clk,
  input wire logic rd,
  input wire logic [15:0] addr,
  output logic [31:0] rdata,
  input wire logic wr,
  input wire logic [7:0] waddr,
  input wire logic [31:0] wdata
);
  logic [31:0] mem [256];
  // writes land on the clock
  always @(posedge clk) begin
    if (wr) mem[waddr] <= wdata;
  end
  // word stands while the registered request does; inverted otherwise so stale words never pass
  assign rdata = rd ? mem[addr[7:0]] : ~mem[addr[7:0]];
endmodule

// ==== testbench/cfe_filter_core_tb.sv ====
/*
  Self-checking bench for the filter and transmit-event core.
  Assumes the checker is bound and the RAM model answers the read port.
*/
`timescale 1ns/100ps
module cfe_filter_core_tb;
  typedef struct packed {logic [31:0] w0; logic [15:0] hi; logic [6:0] b;
    logic c; logic [15:0] dts;} cfe_tx_exp_t;
  typedef struct packed {cfe_pkg::cfe_rx_result_t r; logic [2:0] fe; logic [1:0] dst;} cfe_rx_exp_t;
  logic CLK = 0, RST_N = 0, NO_AUTO_RETRANSMIT_MODE = 0, TX_SOF = 0, TX_DONE = 0, wr = 0;
  logic RX_START = 0, RX_XTD = 0, HPM_CLEAR = 0, HPM_IE = 0, have = 0;
  logic EVT_WR, RX_BUSY, RAM_RD, RES_VALID, HIGH_PRIORITY_MATCH_FLAG, HPM_IRQ;
  logic [3:0] TIMESTAMP_PRESCALER = 4'h0, last_pre = 4'h0;
  logic [28:0] RX_ID = 29'h0;
  logic [31:0] EVT_WORD0, EVT_WORD1, RAM_RDATA, r, wdata = 32'h0, seed = 32'h0000290B;
  logic [6:0] EVT_BYTES;
  logic [15:0] RAM_ADDR, last_ts = 16'h0;
  logic [7:0] waddr = 8'h0;
  logic [2:0] FILTER_EVENT_PULSES;
  logic [1:0] ft [2][8];
  logic [2:0] fa [2][8];
  logic [28:0] f1 [2][8], f2 [2][8];
  logic [29:0] qs [15] = '{30'h150, 30'h456, 30'h2AF, 30'h3FF, 30'h555, 30'h556, 30'h7FF,
    30'h21000000, 30'h21FFFFFF, 30'h20ABCDEF, 30'h21234567, 30'h20F12345, 30'h20000775,
    30'h3FFFFFFF, 30'h123};
  cfe_pkg::cfe_tx_frame_t TX_FRAME = '0;
  cfe_pkg::cfe_filt_cfg_t FILT_CFG = '0;
  cfe_pkg::cfe_rx_result_t RES;
  cfe_pkg::cfe_hpm_status_t HIGH_PRIORITY_STATUS;
  cfe_tx_exp_t txq [$], te;
  cfe_rx_exp_t rxq [$], re;
  int n_mismatch = 0, checked = 0, cyc = 0, last_sof = 0;
  cfe_filter_core u_dut (.CLK, .RST_N, .TIMESTAMP_PRESCALER, .NO_AUTO_RETRANSMIT_MODE, .TX_SOF,
    .TX_DONE, .TX_FRAME, .EVT_WR, .EVT_WORD0, .EVT_WORD1, .EVT_BYTES, .FILT_CFG, .RX_START,
    .RX_ID, .RX_XTD, .RX_BUSY, .RAM_RD, .RAM_ADDR, .RAM_RDATA, .RES_VALID, .RES, .HPM_CLEAR,
    .HPM_IE, .HIGH_PRIORITY_MATCH_FLAG, .HPM_IRQ, .HIGH_PRIORITY_STATUS, .FILTER_EVENT_PULSES);
  cfe_ram_model u_ram (.clk(CLK), .rd(RAM_RD), .addr(RAM_ADDR), .rdata(RAM_RDATA), .wr(wr),
    .waddr(waddr), .wdata(wdata));
  // clock and run limit
  always #50 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // payload size of a data length code
  function automatic logic [6:0] nb(input logic [3:0] d, input logic fd);
    if (d <= 4'h8) return {3'h0, d};
    if (!fd) return 7'h08;
    if (d < 4'hD) return 7'h0C + {1'b0, d - 4'h9, 2'h0};
    return d == 4'hD ? 7'h20 : (d == 4'hE ? 7'h30 : 7'h40);
  endfunction
  // expected decision of the bench's own copy of the lists
  function automatic cfe_pkg::cfe_rx_result_t ref_res(input logic x, input logic [28:0] rid,
    output logic [2:0] fe, output logic [1:0] dst);
    cfe_pkg::cfe_rx_result_t o;
    logic [28:0] v, m, a1, a2;
    logic [2:0] a;
    logic hit;
    o = '0;
    o.ext = x;
    fe = 3'h0;
    dst = 2'h0;
    v = x ? rid : {18'h0, rid[28:18]};
    for (int i = 0; i < (x ? FILT_CFG.ext_count : FILT_CFG.std_count); i++) begin
      a = fa[x][i];
      a1 = f1[x][i];
      a2 = f2[x][i];
      m = (x && (ft[x][i] != 2'h3 || a == 3'h7)) ? v & FILT_CFG.global_ext_and_mask : v;
      if (a == 3'h7) hit = m == a1;
      else if (ft[x][i] == 2'h1) hit = m == a1 || m == a2;
      else if (ft[x][i] == 2'h2) hit = (m & a2) == (a1 & a2);
      else hit = m >= a1 && m <= a2;
      if (a == 3'h0 || (!x && ft[x][i] == 2'h3 && a != 3'h7)) hit = 1'b0;
      if (hit && !o.matched) begin
        o.matched = 1'b1;
        o.index = 7'(i);
        o.action = a;
        o.priority_set = a inside {3'h4, 3'h5, 3'h6};
        dst = a == 3'h5 ? 2'h1 : (a == 3'h6 ? 2'h2 : 2'h0);
        if (a == 3'h7) begin
          o.route = a2[10:9];
          fe = a2[8:6];
          if (a2[10:9] == 2'h0) o.buf_addr = FILT_CFG.rx_buffer_base + {10'h0, a2[5:0]};
        end
      end
    end
    return o;
  endfunction
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
    checked++;
    if (e !== s) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrm(input logic [15:0] a, input logic [31:0] d);
    @(posedge CLK); #1;
    wr = 1'b1;
    waddr = a[7:0];
    wdata = d;
  endtask
  task automatic el(input logic x, input int i, input logic [1:0] t, input logic [2:0] a,
    input logic [28:0] p1, input logic [28:0] p2);
    ft[x][i] = t;
    fa[x][i] = a;
    f1[x][i] = p1;
    f2[x][i] = p2;
    if (x) begin
      wrm(FILT_CFG.ext_filter_list_base + 16'(2 * i), {a, p1});
      wrm(FILT_CFG.ext_filter_list_base + 16'(2 * i + 1), {t, 1'b0, p2});
    end else wrm(FILT_CFG.std_filter_list_base + 16'(i), {t, a, p1[10:0], 5'h0, p2[10:0]});
  endtask
  // one transmission: start pulse, gap, done pulse with the frame
  task automatic tx(input int gap, input logic [3:0] dlc, input logic fd, input logic st);
    cfe_pkg::cfe_tx_frame_t f;
    cfe_tx_exp_t e;
    f = {xs(), 16'(xs())};
    f.dlc = dlc;
    f.fdf = fd;
    f.store_event = st;
    @(posedge CLK); #1;
    TX_SOF = 1'b1;
    e.c = have && TIMESTAMP_PRESCALER == last_pre;
    e.dts = 16'((cyc - last_sof) / (TIMESTAMP_PRESCALER + 1));
    if (st) begin
      last_sof = cyc;
      last_pre = TIMESTAMP_PRESCALER;
      have = 1'b1;
    end
    @(posedge CLK); #1;
    TX_SOF = 1'b0;
    repeat (gap) begin
      @(posedge CLK); #1;
    end
    TX_DONE = 1'b1;
    TX_FRAME = f;
    e.w0 = {f.esi, f.xtd, f.rtr, f.xtd ? f.id : {f.id[28:18], 18'h0}};
    e.hi = {f.message_marker, (f.cancel_req || NO_AUTO_RETRANSMIT_MODE) ? 2'h2 : 2'h1,
      f.fdf, f.brs, f.dlc};
    e.b = nb(dlc, fd);
    if (st) txq.push_back(e);
    @(posedge CLK); #1;
    TX_DONE = 1'b0;
  endtask
  // one filter request, optionally repeated while the walk is busy
  task automatic q(input logic x, input logic [28:0] id, input logic pk);
    cfe_rx_exp_t e;
    int k;
    @(posedge CLK); #1;
    RX_ID = x ? id : {id[10:0], 18'h0};
    e.r = ref_res(x, RX_ID, e.fe, e.dst);
    rxq.push_back(e);
    RX_START = 1'b1;
    RX_XTD = x;
    HPM_IE = xs() > 32'h80000000;
    @(posedge CLK); #1;
    RX_START = pk;
    @(posedge CLK); #1;
    RX_START = 1'b0;
    for (k = 0; k < 1000 && rxq.size() != 0; k++) @(posedge CLK);
    if (k == 1000) chk("result wait", 1, 0);
  endtask
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // scoreboard on settled outputs
  always @(negedge CLK) begin
    if (RST_N && EVT_WR === 1'b1) begin
      te = txq.pop_front();
      chk("event word0", te.w0, EVT_WORD0);
      chk("event word1 high", te.hi, EVT_WORD1[31:16]);
      chk("event bytes", te.b, EVT_BYTES);
      if (te.c) chk("timestamp step", te.dts, EVT_WORD1[15:0] - last_ts);
      last_ts = EVT_WORD1[15:0];
    end
    if (RST_N && RES_VALID === 1'b1) begin
      re = rxq.pop_front();
      chk("result", re.r, RES);
      chk("filter events", re.fe, FILTER_EVENT_PULSES);
      if (re.r.priority_set) chk("priority status", {re.r.ext, re.r.index, re.dst},
        HIGH_PRIORITY_STATUS);
    end
  end
  initial begin
    repeat (6) @(posedge CLK);
    #1;
    RST_N = 1'b1;
    for (int i = 0; i < 36; i++) begin
      NO_AUTO_RETRANSMIT_MODE = i >= 32;
      TIMESTAMP_PRESCALER = i >= 34 ? 4'h3 : 4'h0;
      tx(i >= 34 ? 1 : i % 3, 4'(i), i[4], i != 33);
    end
    FILT_CFG = {16'h0010, 8'h06, 16'h0040, 7'h06, 16'h0200, 29'h1FFFFFF0};
    el(0, 0, 2'h3, 3'h1, 29'h100, 29'h1FF);
    el(0, 1, 2'h1, 3'h3, 29'h123, 29'h456);
    el(0, 2, 2'h2, 3'h5, 29'h2A0, 29'h7F0);
    el(0, 3, 2'h0, 3'h4, 29'h300, 29'h3FF);
    el(0, 4, 2'h3, 3'h7, 29'h555, 29'h145);
    el(0, 5, 2'h0, 3'h7, 29'h556, 29'h683);
    el(1, 0, 2'h0, 3'h0, 29'h0, 29'h1FFFFFFF);
    el(1, 1, 2'h3, 3'h2, 29'h1000000, 29'h1FFFFFF);
    el(1, 2, 2'h1, 3'h6, 29'h0ABCDE0, 29'h123);
    el(1, 3, 2'h0, 3'h7, 29'h1234560, 29'h3C7);
    el(1, 4, 2'h2, 3'h1, 29'h0F00000, 29'h1FF00000);
    el(1, 5, 2'h1, 3'h7, 29'h0000770, 29'h440);
    @(posedge CLK); #1;
    wr = 1'b0;
    for (int k = 0; k < 15; k++) q(qs[k][29], qs[k][28:0], k == 1);
    for (int k = 0; k < 40; k++) begin
      r = xs();
      q(r[0], r[0] ? 29'(r[27:3]) : 29'(r[13:3]), 1'b0);
    end
    q(0, 29'h3FF, 0);
    @(negedge CLK);
    chk("priority flag", 1, HIGH_PRIORITY_MATCH_FLAG);
    @(posedge CLK); #1;
    HPM_CLEAR = 1'b1;
    @(posedge CLK); #1;
    HPM_CLEAR = 1'b0;
    @(negedge CLK);
    chk("priority flag", 0, HIGH_PRIORITY_MATCH_FLAG);
    FILT_CFG.std_count = 8'h00;
    q(0, 29'h456, 0);
    chk("queues left", 0, txq.size() + rxq.size());
    give_verdict();
  end
endmodule
